// [rtl/dac_control_pkg.sv]
package dac_control_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [1:0] IDX_CONVERTER_CONTROL = 2'h0;
    localparam logic [1:0] IDX_CONVERTER_VALUE = 2'h1;
    localparam logic [1:0] IDX_CONVERTER_STATUS = 2'h2;
    // Field positions in the control and status registers.
    localparam int BIT_ENABLE = 0;
    localparam int BIT_OUTPUT_BUFFER_ON = 6;
    localparam int BIT_KEEP_RUNNING_IN_STANDBY = 7;
    localparam int BIT_BUSY = 0;
    // Values after reset.
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] VALUE_RESET = 8'h00;
    // Clock rate and the highest conversion rate the converter takes.
    localparam int CLK_HZ = 10_000_000;
    localparam int MAX_SAMPLES_PER_S = 350_000;
    // Shortest conversion period, rounded down so no rate within the limit is refused.
    localparam int CONV_CYCLES_RAW = CLK_HZ / MAX_SAMPLES_PER_S;
    localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    localparam logic [7:0] CONV_CYCLES_W = CONV_CYCLES[7:0];

    // Bus handshake states, one-hot.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;
endpackage

// [rtl/dac_control_registers.sv]
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ns
// Behaviour
// - Control bit 0 set switches the converter on; cleared keeps it off.
// - Control bit 6 set, with bit 0 also set, turns the output buffer on and drives the pin.
// - Bit 7 keeps converter and buffer running in standby; else they stop.
// - An 8-bit read/write value register holds the code to convert.
// - A value register write or a rising enable bit starts a conversion, only while enabled and awake.
// - New codes are accepted and applied at up to 350k conversions per second.
module dac_control_registers
    import dac_control_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic standby_sleep,
    output logic converter_on,
    output logic output_buffer_on,
    output logic [7:0] converter_code,
    output logic conversion_start
);

    bus_state_t bus_state_q, bus_state_d;
    logic [7:0] control_q, control_d;
    logic [7:0] value_q, value_d;
    logic [7:0] busy_cnt_q, busy_cnt_d;
    logic [31:0] readdata_d;
    logic wait_d;
    logic conv_on_d;
    logic buf_on_d;
    logic start_d;

    // Word index match, shared by every register decode and by the checks below.
    function automatic logic index_is(input logic [1:0] idx, input logic [1:0] want);
        return idx == want;
    endfunction

    // Address decode: registers sit on aligned words, low address bits ignored.
    // Index three is left unmapped so that it reads zero and swallows writes.
    wire logic request = avs_read | avs_write;
    wire logic [1:0] reg_index = avs_address[3:2];
    wire logic hit_control = index_is(reg_index, IDX_CONVERTER_CONTROL);
    wire logic hit_value = index_is(reg_index, IDX_CONVERTER_VALUE);
    wire logic hit_status = index_is(reg_index, IDX_CONVERTER_STATUS);
    // A write takes effect only at the edge where waitrequest is seen low.
    wire logic commit = (bus_state_q == BUS_ANSWER) & avs_write & avs_byteenable[0];
    wire logic write_control = commit & hit_control;
    wire logic write_value = commit & hit_value;
    wire logic [7:0] wbyte = avs_writedata[7:0];
    // Only the three documented control bits are writable; the rest stay zero.
    wire logic [7:0] control_mask = 8'hc1;
    wire logic busy = busy_cnt_q != 8'h00;

    // Standby gating: the converter runs only if not asleep or told to keep running.
    // The incoming control byte is used so an enable written in standby together with bit 7 starts at once.
    wire logic awake_ok = ~standby_sleep | control_d[BIT_KEEP_RUNNING_IN_STANDBY];
    wire logic enable_now = control_d[BIT_ENABLE];
    wire logic enable_rise = enable_now & ~control_q[BIT_ENABLE];

    // Handshake: one cycle of wait, then one cycle with waitrequest low.
    always_comb begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            BUS_IDLE: begin
                if (request) begin
                    bus_state_d = BUS_ANSWER;
                end
            end
            BUS_ANSWER: bus_state_d = BUS_IDLE;
            default: bus_state_d = BUS_IDLE;
        endcase
    end

    assign wait_d = bus_state_d != BUS_ANSWER;

    // Read data is captured as the answer is prepared; unmapped words read zero.
    always_comb begin
        readdata_d = 32'h0000_0000;
        if (bus_state_q == BUS_IDLE && avs_read) begin
            if (hit_control) begin
                readdata_d = {24'h00_0000, control_q};
            end else if (hit_value) begin
                readdata_d = {24'h00_0000, value_q};
            end else if (hit_status) begin
                readdata_d = {31'h0000_0000, busy};
            end
        end
    end

    // Register writes; the value is stored whatever the enable state.
    assign control_d = write_control ? (wbyte & control_mask) : control_q;
    assign value_d = write_value ? wbyte : value_q;

    // A value write or a fresh enable launches a conversion of the stored code.
    assign start_d = (write_value | enable_rise) & enable_now & awake_ok;

    // Pacing counter shows one conversion period; a new code is never refused,
    // so software alone keeps to the rate limit and the status bit helps it.
    assign busy_cnt_d = start_d ? CONV_CYCLES_W : (busy ? busy_cnt_q - 8'h01 : 8'h00);

    // Analogue side controls.
    assign conv_on_d = control_d[BIT_ENABLE] & awake_ok;
    assign buf_on_d = control_d[BIT_ENABLE] & control_d[BIT_OUTPUT_BUFFER_ON] & awake_ok;

    // Bus side flops.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_state_q <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_state_q <= bus_state_d;
            avs_waitrequest <= wait_d;
            avs_readdata <= readdata_d;
        end
    end

    // Register and converter flops.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            control_q <= CONTROL_RESET;
            value_q <= VALUE_RESET;
            busy_cnt_q <= 8'h00;
        end else begin
            control_q <= control_d;
            value_q <= value_d;
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // Outputs to the converter, each straight from a flop.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            converter_on <= 1'b0;
            output_buffer_on <= 1'b0;
            converter_code <= VALUE_RESET;
            conversion_start <= 1'b0;
        end else begin
            converter_on <= conv_on_d;
            output_buffer_on <= buf_on_d;
            converter_code <= value_d;
            conversion_start <= start_d;
        end
    end

    // Checks.
    sequence s_value_write;
        bus_state_q == BUS_ANSWER && avs_write && avs_byteenable[0] && hit_value;
    endsequence

    sequence s_enabled_awake;
        control_d[BIT_ENABLE] && awake_ok;
    endsequence

    a_enable_drives_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conv_on_d |=> converter_on)
        else $error("converter not on after enable");

    a_disabled_stays_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !control_d[BIT_ENABLE] |=> !converter_on && !output_buffer_on)
        else $error("converter on while disabled");

    a_buffer_follows_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_enabled_awake ##0 control_d[BIT_OUTPUT_BUFFER_ON] |=> output_buffer_on)
        else $error("output buffer not on");

    a_standby_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        standby_sleep && !control_d[BIT_KEEP_RUNNING_IN_STANDBY] |=> !converter_on)
        else $error("converter kept running in standby");

    a_standby_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        standby_sleep && control_d[BIT_KEEP_RUNNING_IN_STANDBY] && control_d[BIT_ENABLE]
        |=> converter_on)
        else $error("converter stopped in standby despite keep running");

    a_value_stored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_value_write |=> value_q == $past(avs_writedata[7:0]) && converter_code == value_q)
        else $error("value register did not store write");

    a_write_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_value_write ##0 s_enabled_awake |=> conversion_start)
        else $error("value write did not start conversion");

    a_start_has_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conversion_start |-> $past(write_value) || $rose(control_q[BIT_ENABLE]))
        else $error("conversion started without a trigger");

    a_rate_accepted: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conversion_start |-> busy_cnt_q == CONV_CYCLES_W ##1 busy[*8])
        else $error("pacing counter wrong after start");

    a_readback_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus_state_q == BUS_IDLE && avs_read && hit_value
        ##1 !avs_waitrequest |-> avs_readdata[7:0] == value_q && avs_readdata[31:8] == 24'h0)
        else $error("read of value register wrong");

    a_enable_uses_stored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        enable_rise && awake_ok |=> conversion_start && converter_code == value_q)
        else $error("enable did not convert stored value");

    a_wait_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus_state_q == BUS_IDLE && request |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest handshake wrong");

    // The answer cycle of a read, shared by the control and status read-back checks.
    sequence s_read_answer;
        bus_state_q == BUS_IDLE && avs_read ##1 !avs_waitrequest;
    endsequence

    // Independent tally of cycles since the last start. It saturates so that a long
    // idle stretch never wraps round into a false pacing window.
    logic [7:0] since_start_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            since_start_q <= 8'hff;
        end else if (conversion_start) begin
            since_start_q <= 8'h01;
        end else if (since_start_q != 8'hff) begin
            since_start_q <= since_start_q + 8'h01;
        end
    end

    // Reset must leave the bus waiting and the converter side quiet.
    a_reset_quiet: assert property (@(posedge sys_clk)
        !rst_n |=> avs_waitrequest && !converter_on && !output_buffer_on && !conversion_start
        && converter_code == VALUE_RESET && avs_readdata == 32'h0000_0000)
        else $error("outputs not quiet after reset");

    // Handshake state and the registered waitrequest must never drift apart.
    a_state_onehot: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $onehot(bus_state_q))
        else $error("bus state not one-hot");

    a_wait_tracks_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
        avs_waitrequest == (bus_state_q != BUS_ANSWER))
        else $error("waitrequest out of step with bus state");

    // Read data stands only in the answer cycle; a stale word could pass for a reply.
    a_readdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        avs_waitrequest |-> avs_readdata == 32'h0000_0000)
        else $error("read data not zero outside answer");

    a_control_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_read_answer ##0 hit_control |-> avs_readdata[5:1] == 5'h00
        && avs_readdata[31:8] == 24'h00_0000)
        else $error("reserved control bits read nonzero");

    a_status_reads_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_read_answer ##0 hit_status |-> avs_readdata == {31'h0000_0000, $past(busy, 1)})
        else $error("status read does not show busy");

    // Writes that miss lane 0 or land on an unmapped word must leave both registers alone.
    a_byteenable_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        avs_write && !avs_byteenable[0] |=> $stable(value_q) && $stable(control_q))
        else $error("write without lane 0 changed a register");

    a_unmapped_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        commit && !hit_control && !hit_value |=> $stable(value_q) && $stable(control_q))
        else $error("unmapped write changed a register");

    a_code_follows_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
        converter_code == value_q)
        else $error("converter code differs from value register");

    // Only a committed value write may change the stored code, so reads see the last write.
    a_value_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !write_value |=> $stable(value_q))
        else $error("value register changed without a write");

    a_no_start_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !control_d[BIT_ENABLE] |=> !conversion_start)
        else $error("conversion started while disabled");

    a_start_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conversion_start |=> !conversion_start)
        else $error("conversion start longer than one cycle");

    a_buffer_needs_converter: assert property (@(posedge sys_clk) disable iff (!rst_n)
        output_buffer_on |-> converter_on)
        else $error("buffer on without converter");

    a_standby_buffer_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        standby_sleep && !control_d[BIT_KEEP_RUNNING_IN_STANDBY] |=> !output_buffer_on)
        else $error("buffer kept running in standby");

    // Pacing: the counter steps down by one and busy spans exactly one conversion period.
    a_busy_counts_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy && !start_d |=> busy_cnt_q == $past(busy_cnt_q) - 8'h01)
        else $error("pacing counter did not step down");

    a_busy_span: assert property (@(posedge sys_clk) disable iff (!rst_n)
        since_start_q < CONV_CYCLES_W && !conversion_start |-> busy)
        else $error("busy dropped before the conversion period ended");

    a_busy_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
        since_start_q == CONV_CYCLES_W && !conversion_start |-> !busy)
        else $error("busy outlasted the conversion period");

endmodule

// [testbench/dac_control_registers_bench.sv]
`timescale 1ns/1ns
module dac_control_registers_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic standby_sleep = 1'b0;
    logic converter_on;
    logic output_buffer_on;
    logic [7:0] converter_code;
    logic conversion_start;
    logic [31:0] rdata;
    int fail_count = 0;
    int total_checks = 0;
    int starts = 0;
    int s0;

    dac_control_registers dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .standby_sleep(standby_sleep),
        .converter_on(converter_on), .output_buffer_on(output_buffer_on),
        .converter_code(converter_code), .conversion_start(conversion_start));

    // The clock runs at 10 MHz.
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // Counting pulses catches both a missing start and one that lasts two cycles.
    always @(posedge sys_clk) begin
        if (conversion_start === 1'b1) begin
            starts++;
        end
    end

    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus access; the request is held until waitrequest is sampled low.
    task automatic acc(input logic rd, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= ~rd;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge sys_clk);
            n++;
            if (n > 20) begin
                chk("waitrequest timeout", 32'h1, 32'h0);
                results();
            end
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Two edges give the registered outputs time to follow the committed write.
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        acc(1'b0, a, d, 4'h1);
        settle();
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        acc(1'b1, a, 8'h00, 4'hf);
        chk(what, rdata, exp);
    endtask

    // Main sequence: reset, stored code, enable, back-to-back writes, standby gating.
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk("control after reset", 4'h0, 32'h0);
        rd_chk("value after reset", 4'h4, 32'h0);
        s0 = starts;
        wr(4'h4, 8'ha5);
        chk("start while disabled", starts - s0, 32'h0);
        chk("code while disabled", converter_code, 8'ha5);
        rd_chk("value readback", 4'h4, 32'ha5);
        wr(4'h0, 8'h7f);
        chk("converter on", converter_on, 1'b1);
        chk("buffer on", output_buffer_on, 1'b1);
        chk("start on enable", starts - s0, 32'h1);
        rd_chk("control readback", 4'h0, 32'h41);
        acc(1'b0, 4'h4, 8'h11, 4'h0);
        settle();
        rd_chk("masked write ignored", 4'h4, 32'ha5);
        rd_chk("unmapped read", 4'hc, 32'h0);
        s0 = starts;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 4'h4, 8'h30 + 8'(i), 4'h1);
        end
        settle();
        chk("back-to-back starts", starts - s0, 32'h4);
        chk("last code", converter_code, 8'h33);
        rd_chk("status busy", 4'h8, 32'h1);
        repeat (30) @(posedge sys_clk);
        rd_chk("status idle", 4'h8, 32'h0);
        @(posedge sys_clk);
        standby_sleep <= 1'b1;
        settle();
        chk("standby converter off", converter_on, 1'b0);
        chk("standby buffer off", output_buffer_on, 1'b0);
        s0 = starts;
        wr(4'h4, 8'h5a);
        chk("no start in standby", starts - s0, 32'h0);
        wr(4'h0, 8'hc1);
        chk("keep running converter", converter_on, 1'b1);
        chk("keep running buffer", output_buffer_on, 1'b1);
        @(posedge sys_clk);
        standby_sleep <= 1'b0;
        wr(4'h0, 8'h00);
        chk("disabled converter", converter_on, 1'b0);
        s0 = starts;
        wr(4'h0, 8'h01);
        chk("enable only buffer off", output_buffer_on, 1'b0);
        chk("enable only converter", converter_on, 1'b1);
        chk("start on re-enable", starts - s0, 32'h1);
        chk("stored code kept", converter_code, 8'h5a);
        // A reset in mid-run must clear both registers and quiet the converter.
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk("reset converter off", converter_on, 1'b0);
        chk("reset code", converter_code, 8'h00);
        rd_chk("value after mid reset", 4'h4, 32'h0);
        rd_chk("control after mid reset", 4'h0, 32'h0);
        results();
    end
endmodule
